/* File: common/sfh_pkg.sv */
/*
  Shared constants for the serial flash host: timing, opcodes, byte counts,
  direction codes and the frame state encoding.
  Assumes a 125 MHz system clock driving every host register.
*/
package sfh_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  // Half period of the serial clock; four or more cycles cover the input synchroniser
  localparam int SCK_HALF_NS = 32;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Identification read must stay at or below this serial clock rate
  localparam int ID_MAX_MHZ = 85;
  localparam int SCK_MHZ = 1000 / (2 * SCK_HALF_CYC * CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Frame geometry
  localparam int LEN_W = 9;
  localparam int ADDR_USED_BITS = 20;
  localparam logic [LEN_W-1:0] ADDR_BYTES = 9'h003;
  localparam logic [LEN_W-1:0] ONE_LEN = 9'h001;
  localparam logic [LEN_W-1:0] ID_MAX_LEN = 9'h005;
  localparam logic [LEN_W-1:0] PROG_MAX_LEN = 9'h100;
  localparam logic [LEN_W-1:0] OPEN_LEN = 9'h1FF;
  localparam logic [3:0] BITS_SINGLE = 4'h8;
  localparam logic [3:0] BITS_DUAL = 4'h4;
  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_WRITE = 2'h1;
  localparam logic [1:0] DIR_READ = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes
  localparam logic [7:0] OP_READ_FAST2 = 8'h1B;
  localparam logic [7:0] OP_READ_FAST = 8'h0B;
  localparam logic [7:0] OP_READ_SLOW = 8'h03;
  localparam logic [7:0] OP_READ_DUAL = 8'h3B;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_ERASE_CHIP_A = 8'h60;
  localparam logic [7:0] OP_ERASE_CHIP_B = 8'hC7;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_PROG_DUAL = 8'hA2;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'hD0;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_PROTECT = 8'h36;
  localparam logic [7:0] OP_UNPROTECT = 8'h39;
  localparam logic [7:0] OP_PROT_READ = 8'h3C;
  localparam logic [7:0] OP_LOCKDOWN = 8'h33;
  localparam logic [7:0] OP_LOCK_FREEZE = 8'h34;
  localparam logic [7:0] OP_LOCK_READ = 8'h35;
  localparam logic [7:0] OP_OTP_WRITE = 8'h9B;
  localparam logic [7:0] OP_OTP_READ = 8'h77;
  localparam logic [7:0] OP_STAT_READ = 8'h05;
  localparam logic [7:0] OP_STAT_WRITE1 = 8'h01;
  localparam logic [7:0] OP_STAT_WRITE2 = 8'h31;
  localparam logic [7:0] OP_SOFT_RESET = 8'hF0;
  localparam logic [7:0] OP_ID_READ = 8'h9F;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE = 8'hAB;

  ////////////////////////////////////////////////////////////////////////////
  // Frame states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_OPCODE = 8'h02,
    ST_ADDR = 8'h04,
    ST_DUMMY = 8'h08,
    ST_WDATA = 8'h10,
    ST_RDATA = 8'h20,
    ST_FINISH = 8'h40,
    ST_GAP = 8'h80
  } sfh_state_e;

endpackage : sfh_pkg

/* File: core/sfh_tick_gen.sv */
/*
  Half-period tick generator for the serial clock.
  Assumes run is a same-domain level; the count restarts whenever run drops.
*/
`timescale 1ns/1ns
module sfh_tick_gen
  import sfh_pkg::*;
#(
  parameter int HALF_CYC = SCK_HALF_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  output logic tick
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // One pulse every HALF_CYC cycles while a frame is running
  always_comb begin
    cnt_nxt = 8'h00;
    tick_nxt = 1'b0;
    if (run) begin
      if (cnt_r == 8'(HALF_CYC - 1)) begin
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule : sfh_tick_gen

/* File: core/sfh_opcode_table.sv */
/*
  Opcode table: address, dummy, direction, lane width and byte limit per opcode.
  Purely combinational; the caller latches the results at command acceptance.
*/
`timescale 1ns/1ns
module sfh_opcode_table
  import sfh_pkg::*;
(
  input wire logic [7:0] opcode,
  output logic known,
  output logic has_addr,
  output logic [1:0] dummy,
  output logic [1:0] dir,
  output logic dual,
  output logic [LEN_W-1:0] max_len
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode; unknown codes are flagged so that no frame is ever sent for them
  always_comb begin
    known = 1'b1;
    has_addr = 1'b0;
    dummy = 2'h0;
    dir = DIR_NONE;
    dual = 1'b0;
    max_len = OPEN_LEN;
    case (opcode)
      OP_READ_FAST2, OP_OTP_READ: begin // [RULE12] [RULE21]
        has_addr = 1'b1;
        dummy = 2'h2;
        dir = DIR_READ;
      end
      OP_READ_FAST, OP_READ_DUAL: begin // [RULE12] [RULE4]
        has_addr = 1'b1;
        dummy = 2'h1;
        dir = DIR_READ;
        dual = (opcode == OP_READ_DUAL);
      end
      OP_READ_SLOW, OP_PROT_READ, OP_LOCK_READ: begin // [RULE12] [RULE17] [RULE19]
        has_addr = 1'b1;
        dir = DIR_READ;
      end
      OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_PROTECT, OP_UNPROTECT: begin // [RULE13]
        has_addr = 1'b1;
      end
      OP_PROG, OP_PROG_DUAL: begin // [RULE14] [RULE15] [RULE3]
        has_addr = 1'b1;
        dir = DIR_WRITE;
        dual = (opcode == OP_PROG_DUAL);
        max_len = PROG_MAX_LEN;
      end
      OP_LOCKDOWN, OP_LOCK_FREEZE: begin // [RULE18]
        has_addr = 1'b1;
        dir = DIR_WRITE;
        max_len = ONE_LEN;
      end
      OP_OTP_WRITE: begin // [RULE20]
        has_addr = 1'b1;
        dir = DIR_WRITE;
      end
      OP_STAT_WRITE1, OP_STAT_WRITE2, OP_SOFT_RESET: begin // [RULE22]
        dir = DIR_WRITE;
        max_len = ONE_LEN;
      end
      OP_STAT_READ: begin // [RULE22]
        dir = DIR_READ;
      end
      OP_ID_READ: begin // [RULE23]
        dir = DIR_READ;
        max_len = ID_MAX_LEN;
      end
      OP_ERASE_CHIP_A, OP_ERASE_CHIP_B, OP_SLEEP, OP_WAKE, OP_SUSPEND, OP_RESUME,
      OP_WR_ENABLE, OP_WR_DISABLE: begin // [RULE13] [RULE24]
        dir = DIR_NONE;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

endmodule : sfh_opcode_table

/* File: core/sfh_master.sv */
/*
  Host side of a serial flash link: frames one command per chip select,
  shifts opcode, address, dummy and data bytes, and runs dual-lane transfers.
  Assumes a flash device on the pins and a same-clock user on the command,
  write and read ports; the read port has no back-pressure.
*/
// Behaviour
// [RULE1] Sample rising edge, drive falling edge
// [RULE2] Serial clock idles low or high
// [RULE3] Dual program drives both data pins
// [RULE4] Dual read releases the upper pin
// [RULE5] Chip select, then opcode, then payload
// [RULE6] Every byte most significant bit first
// [RULE7] Chip select release ends the frame
// [RULE8] Unknown opcode starts no operation
// [RULE9] Unknown opcode ignores rest of frame
// [RULE10] Early release aborts without any effect
// [RULE11] Three address bytes, top nibble ignored
// [RULE12] Array reads use two, one, none dummies
// [RULE13] Erases take address only; chip none
// [RULE14] Page program takes 1 to 256
// [RULE15] Dual program takes 1 to 256
// [RULE16] Write enable precedes any page program
// [RULE17] Protection readback: address, then data
// [RULE18] Lockdown commands: address plus one byte
// [RULE19] Lockdown readback: address, then data
// [RULE20] OTP write: address, then data bytes
// [RULE21] OTP read: address, two dummies, data
// [RULE22] Status writes one byte; reads many
// [RULE23] Identification returns one to five bytes
// [RULE24] Power-down entry and exit bare opcodes
`timescale 1ns/1ns
module sfh_master
  import sfh_pkg::*;
#(
  parameter int HALF_CYC = SCK_HALF_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_opcode,
  input wire logic [23:0] cmd_addr,
  input wire logic [LEN_W-1:0] cmd_len,
  input wire logic cmd_mode3,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic err,
  output logic cs_n,
  output logic sck,
  input wire logic dual_lane_upper_pin_i,
  output logic dual_lane_upper_pin_o,
  output logic dual_lane_upper_pin_oe_n,
  input wire logic dual_lane_lower_pin_i,
  output logic dual_lane_lower_pin_o,
  output logic dual_lane_lower_pin_oe_n
);

  sfh_state_e state_r, state_nxt;
  logic [7:0] op_r, op_nxt, tx_r, tx_nxt, rx_r, rx_nxt, buf_r, buf_nxt, rd_data_r, rd_data_nxt;
  logic [ADDR_USED_BITS-1:0] addr_r, addr_nxt;
  logic [LEN_W-1:0] len_r, len_nxt, byte_r, byte_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [1:0] dummy_r, dummy_nxt, dir_r, dir_nxt;
  logic has_addr_r, has_addr_nxt, dual_r, dual_nxt, wide_r, wide_nxt, mode3_r, mode3_nxt;
  logic load_r, load_nxt, lead_r, lead_nxt, have_r, have_nxt, wel_r, wel_nxt;
  logic sck_r, sck_nxt, cs_n_r, cs_n_nxt, cmd_ready_r, cmd_ready_nxt, wr_ready_r, wr_ready_nxt;
  logic rd_valid_r, rd_valid_nxt, done_r, done_nxt, err_r, err_nxt;
  logic up_o_r, up_o_nxt, up_oe_n_r, up_oe_n_nxt, lo_o_r, lo_o_nxt, lo_oe_n_r, lo_oe_n_nxt;
  logic up_s1_r, up_s2_r, lo_s1_r, lo_s2_r;
  logic tick, dec_known, dec_has_addr, dec_dual, dec_prog, dual_phase;
  logic [1:0] dec_dummy, dec_dir;
  logic [LEN_W-1:0] dec_max, len_eff;
  sfh_state_e after;
  logic [7:0] next_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  sfh_tick_gen #(.HALF_CYC(HALF_CYC)) u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .run(state_r != ST_IDLE),
    .tick(tick)
  );

  sfh_opcode_table u_table (
    .opcode(cmd_opcode),
    .known(dec_known),
    .has_addr(dec_has_addr),
    .dummy(dec_dummy),
    .dir(dec_dir),
    .dual(dec_dual),
    .max_len(dec_max)
  );

  // Pin inputs pass two flops; only the second is ever read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_s1_r <= 1'b0;
      up_s2_r <= 1'b0;
      lo_s1_r <= 1'b0;
      lo_s2_r <= 1'b0;
    end else begin
      up_s1_r <= dual_lane_upper_pin_i;
      up_s2_r <= up_s1_r;
      lo_s1_r <= dual_lane_lower_pin_i;
      lo_s2_r <= lo_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing: opcode, address, dummies, data, in that order
  function automatic sfh_state_e phase_after(input sfh_state_e st, input logic has_a,
                                             input logic [1:0] dum, input logic [1:0] dr);
    phase_after = (dr == DIR_READ) ? ST_RDATA : ((dr == DIR_WRITE) ? ST_WDATA : ST_FINISH);
    if (st == ST_OPCODE && has_a) begin
      phase_after = ST_ADDR;
    end else if ((st == ST_OPCODE || st == ST_ADDR) && dum != 2'h0) begin
      phase_after = ST_DUMMY;
    end else if (st == ST_WDATA || st == ST_RDATA) begin
      phase_after = ST_FINISH;
    end
  endfunction : phase_after

  // Requested length clamped to the opcode's legal 1..max range
  assign len_eff = (cmd_len == '0) ? ONE_LEN : ((cmd_len > dec_max) ? dec_max : cmd_len); // [RULE14] [RULE23]
  assign dec_prog = (cmd_opcode == OP_PROG) || (cmd_opcode == OP_PROG_DUAL);
  assign dual_phase = dual_r && (state_r == ST_WDATA || state_r == ST_RDATA);
  assign after = phase_after(state_r, has_addr_r, dummy_r, dir_r);

  // Next outgoing byte; address top nibble always sent as zero
  always_comb begin
    next_byte = 8'h00;
    if (state_r == ST_ADDR) begin
      if (byte_r == ADDR_BYTES) begin
        next_byte = {4'h0, addr_r[19:16]}; // [RULE11]
      end else if (byte_r == 9'h002) begin
        next_byte = addr_r[15:8];
      end else begin
        next_byte = addr_r[7:0];
      end
    end else if (state_r == ST_WDATA) begin
      next_byte = buf_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine next state
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    len_nxt = len_r;
    dummy_nxt = dummy_r;
    dir_nxt = dir_r;
    has_addr_nxt = has_addr_r;
    dual_nxt = dual_r;
    mode3_nxt = mode3_r;
    wide_nxt = wide_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    bit_nxt = bit_r;
    byte_nxt = byte_r;
    load_nxt = load_r;
    lead_nxt = lead_r;
    have_nxt = have_r;
    buf_nxt = buf_r;
    wel_nxt = wel_r;
    sck_nxt = sck_r;
    cs_n_nxt = cs_n_r;
    rd_valid_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    done_nxt = 1'b0;
    err_nxt = 1'b0;
    // One byte of write data is held ahead of the shifter
    if (wr_valid && wr_ready_r) begin
      buf_nxt = wr_data;
      have_nxt = 1'b1;
    end
    unique case (state_r)
      ST_IDLE: begin
        sck_nxt = cmd_mode3; // [RULE2]
        if (cmd_valid && cmd_ready_r) begin
          if (!dec_known || (dec_prog && !wel_r)) begin
            err_nxt = 1'b1; // [RULE8] [RULE9] [RULE16]
          end else if (sck_r == cmd_mode3) begin // Wait until the clock idles at the new mode's level [RULE2]
            op_nxt = cmd_opcode;
            addr_nxt = cmd_addr[ADDR_USED_BITS-1:0]; // [RULE11]
            len_nxt = len_eff;
            dummy_nxt = dec_dummy;
            dir_nxt = dec_dir;
            has_addr_nxt = dec_has_addr;
            dual_nxt = dec_dual;
            mode3_nxt = cmd_mode3;
            wide_nxt = 1'b0;
            tx_nxt = cmd_opcode; // [RULE5]
            bit_nxt = BITS_SINGLE;
            byte_nxt = ONE_LEN; // Opcode phase is exactly one byte [RULE5]
            load_nxt = 1'b0;
            lead_nxt = sck_r; // Mode 3 needs one idle fall first
            cs_n_nxt = 1'b0;
            state_nxt = ST_OPCODE;
          end
        end
      end
      ST_OPCODE, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA: begin
        if (tick) begin
          if (!sck_r) begin
            // Rising edge: the device samples, and read data is taken
            sck_nxt = 1'b1; // [RULE1]
            rx_nxt = dual_phase ? {rx_r[5:0], lo_s2_r, up_s2_r} : {rx_r[6:0], lo_s2_r}; // [RULE4] [RULE6]
            bit_nxt = bit_r - 4'h1;
            if (bit_r == 4'h1) begin
              load_nxt = 1'b1;
              if (state_r == ST_RDATA) begin
                rd_valid_nxt = 1'b1;
                rd_data_nxt = rx_nxt;
              end
              if (byte_r == ONE_LEN) begin
                state_nxt = after; // [RULE12] [RULE13]
                byte_nxt = (after == ST_ADDR) ? ADDR_BYTES : ((after == ST_DUMMY) ? {7'h00, dummy_r} : len_r);
              end else begin
                byte_nxt = byte_r - ONE_LEN;
              end
            end
          end else if (lead_r) begin
            sck_nxt = 1'b0;
            lead_nxt = 1'b0;
          end else if (!load_r) begin
            // Falling edge inside a byte: next bit or bit pair
            sck_nxt = 1'b0; // [RULE1]
            tx_nxt = wide_r ? {tx_r[5:0], 2'b00} : {tx_r[6:0], 1'b0}; // [RULE6]
          end else if (state_r != ST_WDATA || have_r) begin
            // Falling edge at a byte boundary; write data may stall the clock here
            sck_nxt = 1'b0;
            load_nxt = 1'b0;
            wide_nxt = dual_phase; // [RULE3] [RULE4]
            bit_nxt = dual_phase ? BITS_DUAL : BITS_SINGLE;
            tx_nxt = next_byte;
            if (state_r == ST_WDATA) begin
              have_nxt = 1'b0;
            end
          end
        end
      end
      ST_FINISH: begin
        if (tick) begin
          if (sck_r && !mode3_r) begin
            sck_nxt = 1'b0; // [RULE2]
          end else begin
            // Only whole frames are sent, so the device never sees an early release
            cs_n_nxt = 1'b1; // [RULE7] [RULE10]
            done_nxt = 1'b1;
            state_nxt = ST_GAP;
            if (op_r == OP_WR_ENABLE) begin
              wel_nxt = 1'b1; // [RULE16]
            end else if (op_r == OP_WR_DISABLE || op_r == OP_PROG || op_r == OP_PROG_DUAL) begin
              wel_nxt = 1'b0;
            end
          end
        end
      end
      ST_GAP: begin
        if (tick) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cs_n_nxt = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered ports; pin drive follows the lane width latched at the fall
  always_comb begin
    cmd_ready_nxt = (state_nxt == ST_IDLE);
    wr_ready_nxt = (state_nxt == ST_WDATA) && load_nxt && !have_nxt;
    up_o_nxt = cs_n_nxt ? 1'b0 : (wide_nxt ? tx_nxt[6] : tx_nxt[7]);
    lo_o_nxt = cs_n_nxt ? 1'b0 : tx_nxt[7];
    up_oe_n_nxt = !cs_n_nxt && dual_r && dir_r == DIR_READ && (state_nxt == ST_RDATA || state_nxt == ST_FINISH); // [RULE4]
    lo_oe_n_nxt = !(!cs_n_nxt && wide_nxt && dir_r == DIR_WRITE); // [RULE3]
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      op_r <= 8'h00;
      addr_r <= '0;
      len_r <= '0;
      dummy_r <= 2'h0;
      dir_r <= DIR_NONE;
      has_addr_r <= 1'b0;
      dual_r <= 1'b0;
      mode3_r <= 1'b0;
      wide_r <= 1'b0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      bit_r <= 4'h0;
      byte_r <= '0;
      load_r <= 1'b0;
      lead_r <= 1'b0;
      have_r <= 1'b0;
      buf_r <= 8'h00;
      wel_r <= 1'b0;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      cmd_ready_r <= 1'b0;
      wr_ready_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
      done_r <= 1'b0;
      err_r <= 1'b0;
      up_o_r <= 1'b0;
      up_oe_n_r <= 1'b0;
      lo_o_r <= 1'b0;
      lo_oe_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      len_r <= len_nxt;
      dummy_r <= dummy_nxt;
      dir_r <= dir_nxt;
      has_addr_r <= has_addr_nxt;
      dual_r <= dual_nxt;
      mode3_r <= mode3_nxt;
      wide_r <= wide_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      bit_r <= bit_nxt;
      byte_r <= byte_nxt;
      load_r <= load_nxt;
      lead_r <= lead_nxt;
      have_r <= have_nxt;
      buf_r <= buf_nxt;
      wel_r <= wel_nxt;
      sck_r <= sck_nxt;
      cs_n_r <= cs_n_nxt;
      cmd_ready_r <= cmd_ready_nxt;
      wr_ready_r <= wr_ready_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      up_o_r <= up_o_nxt;
      up_oe_n_r <= up_oe_n_nxt;
      lo_o_r <= lo_o_nxt;
      lo_oe_n_r <= lo_oe_n_nxt;
    end
  end

  assign cmd_ready = cmd_ready_r;
  assign wr_ready = wr_ready_r;
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  assign done = done_r;
  assign err = err_r;
  assign cs_n = cs_n_r;
  assign sck = sck_r;
  assign dual_lane_upper_pin_o = up_o_r;
  assign dual_lane_upper_pin_oe_n = up_oe_n_r;
  assign dual_lane_lower_pin_o = lo_o_r;
  assign dual_lane_lower_pin_oe_n = lo_oe_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks; the data counter exists only for them
  logic [LEN_W:0] data_cnt_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_cnt_r <= '0;
    end else if (state_r == ST_IDLE) begin
      data_cnt_r <= '0;
    end else if (rd_valid_r || (wr_valid && wr_ready_r)) begin
      data_cnt_r <= data_cnt_r + 10'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  idle_level_a: assert property ($rose(cs_n_r) |-> sck_r == mode3_r) // [RULE2]
    else $error("serial clock not at idle level when frame ends");
  edge_drive_a: assert property ($changed(up_o_r) |-> $fell(sck_r) || $changed(cs_n_r)) // [RULE1]
    else $error("upper pin changed away from a falling edge");
  read_sample_a: assert property (rd_valid_r |-> $rose(sck_r) && state_r != ST_IDLE) // [RULE1]
    else $error("read byte completed off a rising edge");
  frame_start_a: assert property ($fell(cs_n_r) |-> state_r == ST_OPCODE && up_o_r == op_r[7]) // [RULE5] [RULE6]
    else $error("frame did not open with opcode msb");
  addr_top_a: assert property (state_r == ST_ADDR && byte_r == ADDR_BYTES && bit_r > 4'h4 |-> !up_o_r) // [RULE11]
    else $error("address top nibble not zero");
  dual_read_a: assert property (state_r == ST_RDATA && dual_r |-> up_oe_n_r && lo_oe_n_r) // [RULE4]
    else $error("pins still driven in dual read");
  dual_write_a: assert property (state_r == ST_WDATA && wide_r |-> !lo_oe_n_r && !up_oe_n_r) // [RULE3]
    else $error("both pins not driven in dual program");
  refuse_a: assert property (state_r == ST_IDLE && cmd_valid && cmd_ready_r && !dec_known |=> err_r && cs_n_r) // [RULE8]
    else $error("unknown opcode was not refused");
  wel_order_a: assert property ($fell(cs_n_r) && (op_r == OP_PROG || op_r == OP_PROG_DUAL) |-> wel_r) // [RULE16]
    else $error("program sent without write enable");
  frame_end_a: assert property ($rose(cs_n_r) |-> done_r && state_r == ST_GAP ##1 cs_n_r) // [RULE7]
    else $error("frame end not reported");
  data_count_a: assert property ($rose(cs_n_r) |-> data_cnt_r == ((dir_r == DIR_NONE) ? 10'h000 : {1'b0, len_r})) // [RULE14]
    else $error("data byte count differs from frame length");

  dual_read_c: cover property ($rose(cs_n_r) && op_r == OP_READ_DUAL);
  dual_prog_c: cover property ($rose(cs_n_r) && op_r == OP_PROG_DUAL);
  refuse_c: cover property (err_r);
  mode3_c: cover property ($rose(cs_n_r) && mode3_r && dir_r == DIR_READ);

endmodule : sfh_master

/* File: tb/sfh_flash_model.sv */
/*
  Behavioural flash device for the serial host bench: counts every bit it
  samples, records the last 64 of them and answers reads with a fixed byte pattern.
  Also records the lower lane for dual programs; the bench makes the upper
  lane of a dual read from the lower one.
*/
`timescale 1ns/1ns
module sfh_flash_model (
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic lane_lo,
  output logic miso
);
  localparam logic [7:0] PAT = 8'hA5;
  logic [63:0] rx_r = '0;
  logic [7:0] rx2_r = '0;
  int nbits_r = 0;
  ////////////////////////////////////////////////////////////////////////////
  // New frame clears the bit count and rx_r; rx2_r keeps its old bits
  always @(negedge cs_n) begin
    nbits_r = 0;
    rx_r = '0;
  end
  // Sample on rise, first bit lands highest
  always @(posedge sck) if (!cs_n) begin
    rx_r = {rx_r[62:0], mosi};
    rx2_r = {rx2_r[6:0], lane_lo};
    nbits_r++;
  end
  // Drive on fall; a released line toggles so stale data never matches
  initial miso = 1'b0;
  always @(negedge sck or posedge cs_n) miso <= cs_n ? ~miso : PAT[7-(nbits_r%8)];
endmodule : sfh_flash_model

/* File: tb/sfh_master_tb.sv */
/*
  Self-checking bench for the serial flash host with a device model.
  Assumes the host's default half period; inputs change 1 ns after clk rises.
*/
`timescale 1ns/1ns
module sfh_master_tb;
  import sfh_pkg::*;
  logic clk = 0, reset_n = 0, cmd_valid = 0, cmd_mode3 = 0, wr_valid = 0;
  logic [7:0] cmd_opcode = '0, wr_data = '0, rd_data, rd;
  logic [23:0] cmd_addr = '0;
  logic [LEN_W-1:0] cmd_len = '0;
  logic cmd_ready, wr_ready, rd_valid, done, err, cs_n, sck, up_o, up_oe_n, lo_o, lo_oe_n, miso, rf;
  int mismatches = 0, n_compared = 0, cyc = 0;
  // Released upper pin carries the inverse of the device's lower-lane bit
  wire up_w = up_oe_n ? ~miso : up_o;
  wire lo_w = lo_oe_n ? miso : lo_o;
  always #4 clk = ~clk;
  sfh_master DUT (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_mode3(cmd_mode3),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
    .done(done), .err(err), .cs_n(cs_n), .sck(sck), .dual_lane_upper_pin_i(up_w),
    .dual_lane_upper_pin_o(up_o), .dual_lane_upper_pin_oe_n(up_oe_n), .dual_lane_lower_pin_i(lo_w),
    .dual_lane_lower_pin_o(lo_o), .dual_lane_lower_pin_oe_n(lo_oe_n));
  sfh_flash_model u_dev (.cs_n(cs_n), .sck(sck), .mosi(up_w), .lane_lo(lo_w), .miso(miso));
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // One whole command; stops on done or refusal, bounded so a hang is caught
  task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [LEN_W-1:0] n,
                     input logic m3, input logic [15:0] wd);
    logic fin, hs;
    @(posedge clk);
    #1;
    rf = 0;
    fin = 0;
    rd = 8'h00;
    wr_data = wd[15:8];
    wr_valid = 1;
    {cmd_opcode, cmd_addr, cmd_len, cmd_mode3, cmd_valid} = {op, a, n, m3, 1'b1};
    // The command stands until the frame opens or the refusal is seen
    for (int k = 0; k < 4000 && !fin; k++) begin
      @(posedge clk);
      if (rd_valid === 1'b1) rd = rd_data;
      if (done === 1'b1) fin = 1;
      hs = (wr_ready === 1'b1);
      #1;
      if (hs) wr_data = wd[7:0];
      if (cs_n === 1'b0 || err === 1'b1) cmd_valid = 0;
      if (err === 1'b1) rf = 1;
      if (rf) fin = 1;
    end
    if (!fin) begin
      mismatches++;
      $display("mismatch at %0t: command never finished", $time);
    end
    wr_valid = 0;
  endtask : run
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_status();
    run(OP_STAT_READ, 24'h000000, 9'h001, 1'b0, 16'h0000);
    chk(u_dev.rx_r[15:8], 64'h05);
    chk(64'(u_dev.nbits_r), 64'd16);
    chk(rd, 64'hA5);
    chk(sck, 64'h0);
  endtask : t_status
  task automatic t_read3();
    run(OP_READ_FAST, 24'hF12345, 9'h001, 1'b1, 16'h0000);
    chk(u_dev.rx_r[47:16], 64'h0B012345);
    chk(64'(u_dev.nbits_r), 64'd48);
    chk(rd, 64'hA5);
    chk(sck, 64'h1);
  endtask : t_read3
  task automatic t_program();
    run(OP_PROG, 24'h000100, 9'h002, 1'b0, 16'h3CC3);
    chk(rf, 64'h1);
    run(OP_WR_ENABLE, 24'h000000, 9'h001, 1'b0, 16'h0000);
    chk(64'(u_dev.nbits_r), 64'd8);
    run(OP_PROG, 24'h000100, 9'h002, 1'b0, 16'h3CC3);
    chk(u_dev.rx_r[47:0], 64'h020001003CC3);
    chk(64'(u_dev.nbits_r), 64'd48);
  endtask : t_program
  task automatic t_unknown();
    run(8'hFF, 24'h000000, 9'h001, 1'b0, 16'h0000);
    chk(rf, 64'h1);
  endtask : t_unknown
  // Bit counts per frame follow from the opcode's byte layout
  task automatic t_counts();
    logic [7:0] ops [5] = '{8'h20, 8'hC7, 8'hB9, 8'h9F, 8'h77};
    int bits [5] = '{32, 8, 8, 48, 120};
    for (int i = 0; i < 5; i++) begin
      run(ops[i], 24'h000000, 9'h009, 1'b0, 16'h0000);
      chk(64'(u_dev.nbits_r), 64'(bits[i]));
    end
  endtask : t_counts
  // Dual lanes: lower pin carries bits 7,5,3,1 and upper pin 6,4,2,0
  task automatic t_dual();
    run(OP_WR_ENABLE, 24'h000000, 9'h001, 1'b0, 16'h0000);
    run(OP_PROG_DUAL, 24'h000000, 9'h001, 1'b0, 16'hC600);
    chk(u_dev.rx_r[35:0], 64'hA2000000A);
    chk(u_dev.rx2_r[3:0], 64'h9);
    chk(64'(u_dev.nbits_r), 64'd36);
    run(OP_READ_DUAL, 24'h000000, 9'h001, 1'b0, 16'h0000);
    chk(rd, 64'h99);
    chk(64'(u_dev.nbits_r), 64'd44);
  endtask : t_dual
  ////////////////////////////////////////////////////////////////////////////
  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 reset_n = 1;
    t_status();
    t_read3();
    t_program();
    t_unknown();
    t_counts();
    t_dual();
    print_verdict();
  end
endmodule : sfh_master_tb
